// file: bridge_status_register.sv
// Summary of operation
// - own pending legacy interrupt sets pending bit
// - forwarded downstream interrupts never affect pending bit
// - downstream port hot-plug interrupt sets pending bit
// - upstream port pending bit reads zero
// - capability list bit reads constant one
// - master poison flag set when enabled; w1c
// - system error flag on fatal message, enabled
// - poison detected flag on any poisoned arrival
// - target abort sent bit reads zero
// - unsupported status fields and reserved read zero
// - eight-bit revision, writes gated by lock
// - poison enable clear never sets master flag
// - system error enable gates error reporting
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module bridge_status_register
   import bridge_status_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // port strap and interrupt sources
   input  wire logic        is_downstream,
   input  wire logic        own_intx_pending,
   input  wire logic        hotplug_irq,
   input  wire logic        fwd_intx_pending,
   // transaction layer events, one-cycle pulses
   input  wire logic        poison_cpl_rx,
   input  wire logic        poison_wr_tx,
   input  wire logic        poison_tlp_rx,
   input  wire logic        fatal_msg_tx,
   // error reporting toward root complex
   output logic             fatal_report,
   // interrupt
   output logic             irq
);

   logic [15:0]         command_reg;   // poison and serr enables
   logic [7:0]          revision_number;
   logic                write_lock;    // revision write lock
   logic                master_poison_flag;
   logic                system_error_signalled;
   logic                poison_detected_flag;
   logic [EV_WIDTH-1:0] irq_status;
   logic [EV_WIDTH-1:0] irq_mask;
   logic                intx_pending_flag;
   logic [15:0]         bridge_status_reg;
   logic                wr_access;     // apb write completes now
   logic [11:0]         word_index;
   logic                poison_report_enable;
   logic                system_error_report_enable;
   logic                set_mpoison;
   logic                set_syserr;
   logic                set_pdetect;
   logic [EV_WIDTH-1:0] events;
   logic [31:0]         next_prdata;
   logic                next_slverr;

   // index decode used by read and write paths
   function automatic logic hit(input logic [11:0] idx,
                                input logic [11:0] want);
      return idx == want;
   endfunction

   // zero-wait slave: every access completes in its first access cycle
   assign pready     = 1'b1;
   assign word_index = paddr[13:2];
   assign wr_access  = psel & penable & pwrite;

   assign poison_report_enable       = command_reg[PERR_EN_BIT];
   assign system_error_report_enable = command_reg[SERR_EN_BIT];

   // forwarded interrupts deliberately not used in pending bit
   // upstream port forces zero
   assign intx_pending_flag = is_downstream &
                              (own_intx_pending
                               | hotplug_irq);

   assign set_mpoison = poison_report_enable &
                        (poison_cpl_rx | poison_wr_tx);
   assign set_syserr  = fatal_msg_tx & system_error_report_enable;
   assign set_pdetect = poison_tlp_rx;
   // fatal message only leaves when enabled
   assign fatal_report = fatal_msg_tx
                         & system_error_report_enable;

   // assemble status word; unlisted bits read zero
   always_comb begin
      bridge_status_reg              = 16'h0000;
      bridge_status_reg[INTX_BIT]    = intx_pending_flag;
      bridge_status_reg[CAP_LIST_BIT] = 1'b1;
      bridge_status_reg[MPOISON_BIT] = master_poison_flag;
      bridge_status_reg[SYSERR_BIT]  = system_error_signalled;
      bridge_status_reg[PDETECT_BIT] = poison_detected_flag;
   end

   // command register, low two byte lanes
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         command_reg <= COMMAND_RESET;
      end else if (wr_access && hit(word_index, COMMAND_INDEX)) begin
         if (pstrb[0]) begin
            command_reg[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            command_reg[15:8] <= pwdata[15:8];
         end
      end
   end

   // lock register; while set the revision byte ignores writes
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         write_lock <= LOCK_RESET;
      end else if (wr_access && hit(word_index, LOCK_INDEX) && pstrb[0]) begin
         write_lock <= pwdata[0];
      end
   end

   // revision byte
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         revision_number <= REVISION_RESET;
      end else if (wr_access && hit(word_index, REVISION_INDEX)
                   && pstrb[0] && !write_lock) begin
         revision_number <= pwdata[7:0];
      end
   end

   // write-one-to-clear flags; set wins over the clear in the same cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         master_poison_flag     <= 1'b0;
         system_error_signalled <= 1'b0;
         poison_detected_flag   <= 1'b0;
      end else begin
         if (set_mpoison) begin
            master_poison_flag <= 1'b1;
         end else if (wr_access && hit(word_index, STATUS_INDEX)
                      && pstrb[1] && pwdata[MPOISON_BIT]) begin
            master_poison_flag <= 1'b0;
         end
         if (set_syserr) begin
            system_error_signalled <= 1'b1;
         end else if (wr_access && hit(word_index, STATUS_INDEX)
                      && pstrb[1] && pwdata[SYSERR_BIT]) begin
            system_error_signalled <= 1'b0;
         end
         if (set_pdetect) begin
            poison_detected_flag <= 1'b1;
         end else if (wr_access && hit(word_index, STATUS_INDEX)
                      && pstrb[1] && pwdata[PDETECT_BIT]) begin
            poison_detected_flag <= 1'b0;
         end
      end
   end

   // interrupt events mirror the three flag setters
   assign events = {set_pdetect, set_syserr, set_mpoison};

   // sticky interrupt status, write one to clear, set wins
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_status <= '0;
      end else if (wr_access && hit(word_index, IRQ_STATUS_INDEX)
                   && pstrb[0]) begin
         irq_status <= (irq_status & ~pwdata[EV_WIDTH-1:0]) | events;
      end else begin
         irq_status <= irq_status | events;
      end
   end

   // interrupt mask, one enables the source
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_mask <= '0;
      end else if (wr_access && hit(word_index, IRQ_MASK_INDEX)
                   && pstrb[0]) begin
         irq_mask <= pwdata[EV_WIDTH-1:0];
      end
   end

   // level interrupt output
   assign irq = |(irq_status & irq_mask);

   // read mux; unmapped indices answer zero with slave error
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_slverr = 1'b0;
      unique case (1'b1)
         hit(word_index, STATUS_INDEX): begin
            next_prdata[15:0] = bridge_status_reg;
         end
         hit(word_index, REVISION_INDEX): begin
            next_prdata[7:0] = revision_number;
         end
         hit(word_index, COMMAND_INDEX): begin
            next_prdata[15:0] = command_reg;
         end
         hit(word_index, IRQ_STATUS_INDEX): begin
            next_prdata[EV_WIDTH-1:0] = irq_status;
         end
         hit(word_index, IRQ_MASK_INDEX): begin
            next_prdata[EV_WIDTH-1:0] = irq_mask;
         end
         hit(word_index, LOCK_INDEX): begin
            next_prdata[0] = write_lock;
         end
         default: begin
            next_slverr = 1'b1;
         end
      endcase
   end

   // read data and error drive straight from decode; zero-wait slave
   // means registered data would arrive a cycle late
   assign prdata  = next_prdata;
   assign pslverr = psel & penable & (next_slverr | (paddr[1:0] != 2'b00));

   // assertions, one per guarded behaviour

   // a disabled poison report must never raise the master flag
   a_mpoison_gated: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (!poison_report_enable && !master_poison_flag)
      |=> !master_poison_flag)
      else $error("master poison flag set while reporting disabled");

   // either poisoned primary event lands in the master flag when poison reporting is enabled
   a_mpoison_set: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (poison_report_enable && (poison_cpl_rx || poison_wr_tx))
      |=> master_poison_flag)
      else $error("master poison flag missed its event");

   // writing one with no event pending clears the master flag
   a_mpoison_clear: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (wr_access && hit(word_index, STATUS_INDEX) && pstrb[1]
       && pwdata[MPOISON_BIT] && !set_mpoison)
      |=> !master_poison_flag)
      else $error("master poison flag survived its clear");

   // an enabled fatal message sets the system error flag
   a_syserr_set: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (fatal_msg_tx && system_error_report_enable)
      |=> system_error_signalled)
      else $error("system error flag missed its event");

   // with reporting disabled the system error flag stays down
   a_syserr_gated: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (!system_error_report_enable && !system_error_signalled)
      |=> !system_error_signalled)
      else $error("system error flag set while reporting disabled");

   // any poisoned arrival sets the detected flag, enable or not
   a_pdetect_set: assert property (
      @(posedge mclk) disable iff (sys_rst)
      poison_tlp_rx |=> poison_detected_flag)
      else $error("poison detected flag missed its event");

   // writing one with no arrival pending clears the detected flag
   a_pdetect_clear: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (wr_access && hit(word_index, STATUS_INDEX) && pstrb[1]
       && pwdata[PDETECT_BIT] && !set_pdetect)
      |=> !poison_detected_flag)
      else $error("poison detected flag survived its clear");

   // upstream port shows no pending interrupt at all
   a_upstream_zero: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !is_downstream |-> !bridge_status_reg[INTX_BIT])
      else $error("pending bit set on upstream port");

   // the port's own legacy interrupt shows in the pending bit on a downstream port
   a_own_pend: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (is_downstream && own_intx_pending) |-> bridge_status_reg[INTX_BIT])
      else $error("own interrupt not shown");

   // hot-plug controller interrupt shows on a downstream port
   a_hotplug_pend: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (is_downstream && hotplug_irq) |-> bridge_status_reg[INTX_BIT])
      else $error("hot-plug interrupt not shown");

   // interrupts forwarded from below never reach the pending bit
   a_fwd_ignored: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (fwd_intx_pending && !own_intx_pending && !hotplug_irq)
      |-> !bridge_status_reg[INTX_BIT])
      else $error("forwarded interrupt shown in pending bit");

   // capability list indicator is wired to one
   a_caplist_one: assert property (
      @(posedge mclk) disable iff (sys_rst)
      bridge_status_reg[CAP_LIST_BIT])
      else $error("capability list bit not set");

   // unsupported and reserved status fields read zero
   a_fixed_zero: assert property (
      @(posedge mclk) disable iff (sys_rst)
      bridge_status_reg[2:0] == 3'h0 && bridge_status_reg[7:5] == 3'h0
      && bridge_status_reg[13:9] == 5'h00)
      else $error("fixed status bits wrong");

   // a locked revision byte never moves
   a_rev_locked: assert property (
      @(posedge mclk) disable iff (sys_rst)
      write_lock |=> $stable(revision_number))
      else $error("revision changed while locked");

   // writing zero to a flag position leaves the flag set
   a_zero_keeps: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (wr_access && hit(word_index, STATUS_INDEX) && !pwdata[PDETECT_BIT]
       && poison_detected_flag) |=> poison_detected_flag)
      else $error("zero write cleared flag");

   // an event in the clearing cycle wins over the clear
   a_set_wins: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (set_pdetect && wr_access && hit(word_index, STATUS_INDEX)
       && pstrb[1] && pwdata[PDETECT_BIT]) |=> poison_detected_flag)
      else $error("clear beat a same-cycle event");

   // every event lands in the sticky interrupt status
   a_irq_sticky: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (|events) |=> ((irq_status & $past(events)) == $past(events)))
      else $error("interrupt status missed an event");

endmodule

// file: bridge_status_pkg.sv
package bridge_status_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [11:0] STATUS_INDEX     = 12'h006;
   localparam logic [11:0] REVISION_INDEX   = 12'h008;
   localparam logic [11:0] COMMAND_INDEX    = 12'h100;
   localparam logic [11:0] IRQ_STATUS_INDEX = 12'h101;
   localparam logic [11:0] IRQ_MASK_INDEX   = 12'h102;
   localparam logic [11:0] LOCK_INDEX       = 12'h103;
   // status field positions
   localparam int INTX_BIT      = 3;
   localparam int CAP_LIST_BIT  = 4;
   localparam int MPOISON_BIT   = 8;
   localparam int SYSERR_BIT    = 14;
   localparam int PDETECT_BIT   = 15;
   // command field positions
   localparam int PERR_EN_BIT   = 6;
   localparam int SERR_EN_BIT   = 8;
   // interrupt event positions
   localparam int EV_MPOISON    = 0;
   localparam int EV_SYSERR     = 1;
   localparam int EV_PDETECT    = 2;
   localparam int EV_WIDTH      = 3;
   // reset values
   localparam logic [15:0] COMMAND_RESET  = 16'h0000;
   localparam logic [7:0]  REVISION_RESET = 8'h01; // arbitrary value
   localparam logic        LOCK_RESET     = 1'b1;
endpackage

// file: tb_bridge_status_register.sv
`timescale 1ns/1ps
module tb_bridge_status_register;
   import bridge_status_pkg::*;
   // bench signals
   logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd, ex;
   logic [3:0]  pstrb;
   logic        is_downstream, own_intx_pending, hotplug_irq;
   logic        fwd_intx_pending, poison_cpl_rx, poison_wr_tx;
   logic        poison_tlp_rx, fatal_msg_tx, fatal_report, irq, err;
   int          mismatches, samples_checked;
   // level inputs {downstream, own, hotplug, forwarded} and pending bit
   logic [4:0]  rows [4] = '{5'b1100_1, 5'b1010_1, 5'b1001_0, 5'b0111_0};

   bridge_status_register i_bridge_status_register (.mclk(mclk),
      .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .is_downstream(is_downstream),
      .own_intx_pending(own_intx_pending), .hotplug_irq(hotplug_irq),
      .fwd_intx_pending(fwd_intx_pending), .poison_cpl_rx(poison_cpl_rx),
      .poison_wr_tx(poison_wr_tx), .poison_tlp_rx(poison_tlp_rx),
      .fatal_msg_tx(fatal_msg_tx), .fatal_report(fatal_report), .irq(irq));

   // free-running clock, 50 ns period
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // one compare; values stay four-state so unknowns never match
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // apb transfer; read data taken at the edge that samples pready
   task automatic apb(input logic wr, input logic [11:0] idx,
                      input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00}; pwdata <= wd; pstrb <= 4'hF;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // read and compare in one go
   task automatic rdchk(input string what, input logic [11:0] idx,
                        input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      chk(what, exp, rd);
   endtask

   // one-cycle event pulses {cpl, wr, tlp, fatal}; fatal_report seen live
   task automatic ev(input logic [3:0] p, input logic exp_fatal);
      @(posedge mclk);
      {poison_cpl_rx, poison_wr_tx, poison_tlp_rx, fatal_msg_tx} <= p;
      @(posedge mclk);
      if (p[0]) chk("fatal_report", {31'h0, exp_fatal},
                    {31'h0, fatal_report});
      {poison_cpl_rx, poison_wr_tx, poison_tlp_rx, fatal_msg_tx} <= 4'h0;
   endtask

   // single exit point for both normal end and hang
   task automatic stop_test;
      $display("mismatches %0d samples_checked %0d", mismatches,
               samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // watchdog sized well past the roughly 120 cycles the tests need
   initial begin
      repeat (5000) @(posedge mclk);
      mismatches++;
      stop_test();
   end

   initial begin
      mismatches = 0; samples_checked = 0;
      sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 16'h0000; pwdata = 32'h0000_0000; pstrb = 4'h0;
      {is_downstream, own_intx_pending, hotplug_irq, fwd_intx_pending} = 4'h0;
      {poison_cpl_rx, poison_wr_tx, poison_tlp_rx, fatal_msg_tx} = 4'h0;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      rdchk("status", STATUS_INDEX, 32'h0000_0010);
      rdchk("revision", REVISION_INDEX, 32'h0000_0001);
      // table of interrupt sources against the pending bit
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         {is_downstream, own_intx_pending, hotplug_irq, fwd_intx_pending}
            <= rows[i][4:1];
         // capability bit always one above the pending bit
         ex = {27'h0, 1'b1, rows[i][0], 3'h0};
         rdchk("pending", STATUS_INDEX, ex);
      end
      // enables off: only the poisoned arrival may land
      ev(4'b1101, 1'b0);
      rdchk("status", STATUS_INDEX, 32'h0000_0010);
      ev(4'b0010, 1'b0);
      rdchk("status", STATUS_INDEX, 32'h0000_8010);
      apb(1'b1, COMMAND_INDEX, 32'h0000_0140);
      ev(4'b1000, 1'b0);
      rdchk("status", STATUS_INDEX, 32'h0000_8110);
      apb(1'b1, STATUS_INDEX, 32'h0000_0000);
      rdchk("status", STATUS_INDEX, 32'h0000_8110);
      apb(1'b1, STATUS_INDEX, 32'h0000_0100);
      rdchk("status", STATUS_INDEX, 32'h0000_8010);
      ev(4'b0100, 1'b0);
      ev(4'b0001, 1'b1);
      rdchk("status", STATUS_INDEX, 32'h0000_C110);
      // interrupt: masked, unmasked, cleared
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, IRQ_MASK_INDEX, 32'h0000_0007);
      @(posedge mclk);
      chk("irq", 32'h1, {31'h0, irq});
      rdchk("irq status", IRQ_STATUS_INDEX, 32'h0000_0007);
      apb(1'b1, IRQ_STATUS_INDEX, 32'h0000_0007);
      @(posedge mclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b1, STATUS_INDEX, 32'h0000_C100);
      rdchk("status", STATUS_INDEX, 32'h0000_0010);
      // revision held by the lock, writable once unlocked
      apb(1'b1, REVISION_INDEX, 32'h0000_00A5);
      rdchk("revision locked", REVISION_INDEX, 32'h0000_0001);
      apb(1'b1, LOCK_INDEX, 32'h0000_0000);
      apb(1'b1, REVISION_INDEX, 32'h0000_00A5);
      rdchk("revision", REVISION_INDEX, 32'h0000_00A5);
      // unmapped place refuses
      apb(1'b0, 12'h050, 32'h0000_0000);
      chk("pslverr", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      // clear and poisoned arrival in one access cycle: arrival wins
      fork
         apb(1'b1, STATUS_INDEX, 32'h0000_8000);
         begin
            repeat (2) @(posedge mclk);
            poison_tlp_rx <= 1'b1;
            @(posedge mclk);
            poison_tlp_rx <= 1'b0;
         end
      join
      rdchk("set wins", STATUS_INDEX, 32'h0000_8010);
      rdchk("irq status", IRQ_STATUS_INDEX, 32'h0000_0004);
      // reset in mid-run brings every register back to its reset value
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      chk("irq after reset", 32'h0, {31'h0, irq});
      rdchk("status after reset", STATUS_INDEX, 32'h0000_0010);
      rdchk("revision after reset", REVISION_INDEX, 32'h0000_0001);
      rdchk("command after reset", COMMAND_INDEX, 32'h0000_0000);
      rdchk("lock after reset", LOCK_INDEX, 32'h0000_0001);
      chk("pslverr mapped", 32'h0, {31'h0, err});
      stop_test();
   end
endmodule
